/* File: valve_power_enable_sequencer_tb.sv */
/*
  Self-checking bench for the valve power enable sequencer.
  Assumes MS_CYCLES of 4 and the far-side model driving the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module valve_power_enable_sequencer_tb;
  import vpes_pkg::*;
  localparam int MS = 4;
  logic         pclk, presetn, psel, penable, pwrite, fault;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, r;
  logic         pready, pslverr, e, irq, power_grant, vel_enable;
  logic         supply_low, central_en_pin, module_en_pin, order_err;
  logic         sup_ok, cen, men;
  vpes_valves_t valves;
  int           miscompares, checks;

  vpes_seq #(.MS_CYCLES(MS)) i_dut (
    .pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_low(supply_low), .central_en_pin(central_en_pin),
    .module_en_pin(module_en_pin), .internal_fault_source(fault),
    .valves(valves), .power_grant(power_grant), .vel_enable(vel_enable),
    .irq(irq));

  vpes_valve_supply i_far (
    .pclk(pclk), .presetn(presetn), .supply_ok(sup_ok), .central_on(cen),
    .module_on(men), .valves(valves), .supply_low(supply_low),
    .central_en_pin(central_en_pin), .module_en_pin(module_en_pin),
    .order_err(order_err));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd_v, output logic err);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v);
    logic y;
    apb(1'b0, a, 32'h0, v, y);
  endtask : rd

  function automatic logic cur(input int s);
    case (s)
      0: cur = valves.servo;
      1: cur = valves.shutoff;
      2: cur = power_grant;
      default: cur = vel_enable;
    endcase
  endfunction : cur

  // edges until the chosen output reaches v, checked against a window
  task measure(input int s, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (cur(s) !== v && n <= hi) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : measure

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results();
  end

  initial begin
    logic [7:0]  ra [7];
    logic [31:0] rv [7];
    ra = '{ADDR_PED, ADDR_CFG, ADDR_OED, ADDR_CTRL, ADDR_STAT, ADDR_ISTAT,
           ADDR_IMASK};
    rv = '{32'h64, 32'h4, 32'h12C, 32'h0, 32'h0, 32'h0, 32'h0};
    {presetn, psel, penable, pwrite, fault, cen} = 6'h0;
    {paddr, pwdata, miscompares, checks} = '0;
    {sup_ok, men} = 2'h3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], r);
      chk(r, rv[i]);
    end
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(ADDR_PED, 32'hFFFF);
    rd(ADDR_PED, r);
    chk(r, 32'(PED_MAX));
    wr(ADDR_OED, 32'hFFFF);
    rd(ADDR_OED, r);
    chk(r, 32'(OED_MAX));
    wr(ADDR_PED, 32'h5);
    wr(ADDR_OED, 32'h3);
    wr(ADDR_CFG, 32'h1);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_IMASK, 32'hF);
    cen <= 1'b1;
    measure(0, 1'b1, 0, 10);
    measure(1, 1'b1, 5 * MS, 5 * MS + 4);
    chk(32'(power_grant), 32'h1);
    measure(3, 1'b1, 3 * MS, 3 * MS + 4);
    for (int s = 0; s < 4; s++) begin
      case (s)
        0: cen <= 1'b0;
        1: men <= 1'b0;
        2: wr(ADDR_CTRL, 32'h2);
        default: fault <= 1'b1;
      endcase
      measure(2, 1'b0, 0, 8);
      chk({cur(0), cur(1), cur(3)}, 32'h4);
      {cen, men, fault} <= 3'h6;
      if (s == 2) wr(ADDR_CTRL, 32'h3);
      measure(1, 1'b1, 0, 8);
      measure(3, 1'b1, 3 * MS, 3 * MS + 4);
    end
    fault <= 1'b1;
    measure(2, 1'b0, 0, 4);
    measure(0, 1'b0, 3 * MS - 2, 3 * MS + 4);
    wr(ADDR_CFG, 32'h11);
    fault <= 1'b0;
    measure(3, 1'b1, 0, 60);
    fault <= 1'b1;
    measure(2, 1'b0, 0, 4);
    repeat (30) @(posedge pclk);
    chk(32'(valves.servo), 32'h1);
    wr(ADDR_CFG, 32'h0);
    fault <= 1'b0;
    measure(1, 1'b1, 0, 4);
    measure(3, 1'b1, 0, 30);
    fault <= 1'b1;
    measure(0, 1'b0, 0, 4);
    fault <= 1'b0;
    measure(3, 1'b1, 0, 60);
    sup_ok <= 1'b0;
    measure(2, 1'b0, 0, 6);
    chk({cur(0), cur(1), cur(3)}, 32'h0);
    rd(ADDR_STAT, r);
    chk(r & 32'h1, 32'h1);
    chk(32'(irq), 32'h1);
    wr(ADDR_IMASK, 32'h0);
    chk(32'(irq), 32'h0);
    rd(ADDR_ISTAT, r);
    chk(r & 32'h1, 32'h1);
    wr(ADDR_ISTAT, 32'hF);
    rd(ADDR_ISTAT, r);
    chk(r, 32'h0);
    repeat (40) @(posedge pclk);
    chk({cur(2), cur(3)}, 32'h0);
    sup_ok <= 1'b1;
    measure(0, 1'b1, 0, 8);
    measure(2, 1'b1, 5 * MS, 5 * MS + 4);
    rd(ADDR_ISTAT, r);
    chk(r & 32'h2, 32'h2);
    measure(3, 1'b1, 0, 30);
    wr(ADDR_CTRL, 32'h1);
    measure(3, 1'b0, 0, 4);
    chk(32'(power_grant), 32'h1);
    chk(32'(order_err), 32'h0);
    results();
  end
endmodule : valve_power_enable_sequencer_tb
`default_nettype wire

/* File: vpes_ms_timer.sv */
/*
  Millisecond delay timer with its own prescaler.
  Assumes run stays high while the delay is wanted; dropping it restarts.
*/
`timescale 1ns/1ps
`default_nettype none
module vpes_ms_timer
  import vpes_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  // control
  input  wire logic        run,
  input  wire logic [15:0] limit_ms,
  output logic             done
);
  logic [19:0] cyc;
  logic [19:0] next_cyc;
  logic [15:0] ms;
  logic [15:0] next_ms;

  assign done = run && (ms >= limit_ms);

  always_comb begin
    next_cyc = cyc;
    next_ms  = ms;
    if (!run) begin
      next_cyc = '0;
      next_ms  = '0;
    end else if (!done) begin
      if (cyc == 20'(MS_CYCLES - 1)) begin
        next_cyc = '0;
        next_ms  = ms + 16'h0001;
      end else begin
        next_cyc = cyc + 20'h00001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc <= '0;
      ms  <= '0;
    end else if (pce) begin
      cyc <= next_cyc;
      ms  <= next_ms;
    end
  end
endmodule : vpes_ms_timer
`default_nettype wire

/* File: vpes_pkg.sv */
/*
  Package for the valve power enable sequencer: register map, reset
  values, field positions, timing constants, states and carrier types.
  Assumes a single 250 MHz clock and a 32-bit APB register port.
*/
`default_nettype none
package vpes_pkg;
  // register byte addresses
  localparam logic [7:0]  ADDR_PED    = 8'h00;
  localparam logic [7:0]  ADDR_CFG    = 8'h04;
  localparam logic [7:0]  ADDR_OED    = 8'h08;
  localparam logic [7:0]  ADDR_CTRL   = 8'h0C;
  localparam logic [7:0]  ADDR_STAT   = 8'h10;
  localparam logic [7:0]  ADDR_ISTAT  = 8'h14;
  localparam logic [7:0]  ADDR_IMASK  = 8'h18;
  // reset values and limits
  localparam logic [15:0] PED_RESET   = 16'h0064;
  localparam logic [15:0] PED_MAX     = 16'h012C;
  localparam logic [15:0] CFG_RESET   = 16'h0004;
  localparam logic [15:0] CFG_MASK    = 16'h001F;
  localparam logic [15:0] OED_RESET   = 16'h012C;
  localparam logic [15:0] OED_MAX     = 16'h01F4;
  // config fields
  localparam int CFG_SHUTOFF  = 0;
  localparam int CFG_AXIS_SOV = 1;
  localparam int CFG_KEEP_SRV = 4;
  // control fields
  localparam int CTRL_PWR     = 0;
  localparam int CTRL_VEL     = 1;
  // interrupt events
  localparam int EV_LOST      = 0;
  localparam int EV_BACK      = 1;
  localparam int EV_VEL       = 2;
  localparam int EV_REVOKE    = 3;
  localparam int NUM_EV       = 4;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_PE  = 3'h1,
    ST_OE  = 3'h3,
    ST_RUN = 3'h2,
    ST_PD  = 3'h6
  } vpes_state_t;

  typedef struct packed {
    logic central;
    logic module_en;
    logic ctrl_word;
    logic fault_free;
  } vpes_src_t;

  typedef struct packed {
    logic servo;
    logic shutoff;
  } vpes_valves_t;

  function automatic logic [15:0] vpes_clamp(input logic [15:0] v,
                                             input logic [15:0] lim);
    vpes_clamp = (v > lim) ? lim : v;
  endfunction : vpes_clamp
endpackage : vpes_pkg
`default_nettype wire

/* File: vpes_seq.sv */
/*
  Valve power enable sequencer top: APB registers, power grant logic,
  valve supply switching and velocity controller enable.
  Assumes supply_low and the enable pins are asynchronous levels and
  internal_fault comes from logic on pclk.
*/
// Summary of operation
// - supply-missing flag follows the synchronised supply-low pin
// - while supply missing, no power grant and velocity enable zero
// - supply loss during operation drops power and sets the supply-lost interrupt event
// - after supply returns, power waits the full power enable delay
// - power enable delay in ms, default 100, clamped to 300
// - shut-off supply held off during the power enable delay
// - four sources: central pin, module pin, control word, fault
// - config bit 0 selects operation with a shut-off valve
// - output enable delay, default 300 ms, clamped to 500
// - with shut-off valve, servo supply cut after output delay
// - power enable switches servo supply on at once
// - shut-off supply at once if servo was on, else after delay
// - velocity enable only after output enable delay ran down
// - disable drops shut-off supply; without valve servo too
// - config bit 4 keeps servo supply on after disable, with shut-off valve only
// - velocity enable needs request, delay, supplies, power, no fault
`timescale 1ns/1ps
`default_nettype none
module vpes_seq
  import vpes_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        supply_low,
  input  wire logic        central_en_pin,
  input  wire logic        module_en_pin,
  input  wire logic        internal_fault_source,
  // outputs
  output var vpes_valves_t valves,
  output logic             power_grant,
  output logic             vel_enable,
  output logic             irq
);
  logic [2:0]         pins_s;
  logic               supply_low_s;
  vpes_src_t          src;
  logic               power_req;
  logic               has_shutoff;
  logic               keep_servo;
  logic               pe_done;
  logic               oe_done;
  vpes_state_t        state;
  vpes_state_t        next_state;
  vpes_valves_t       next_valves;
  logic               next_power_grant;
  logic               next_vel_enable;
  logic               supply_missing;
  logic               pe_run;
  logic               next_pe_run;
  logic               oe_run;
  logic               next_oe_run;
  logic [15:0]        ped;
  logic [15:0]        next_ped;
  logic [15:0]        cfg;
  logic [15:0]        next_cfg;
  logic [15:0]        oed;
  logic [15:0]        next_oed;
  logic [1:0]         ctrl;
  logic [1:0]         next_ctrl;
  logic [NUM_EV-1:0]  istat;
  logic [NUM_EV-1:0]  next_istat;
  logic [NUM_EV-1:0]  imask;
  logic [NUM_EV-1:0]  next_imask;
  logic [NUM_EV-1:0]  ev;
  logic [31:0]        next_prdata;
  logic               next_pready;
  logic               next_pslverr;
  logic               next_irq;
  logic               wr;
  logic               setup;
  vpes_sync #(.WIDTH(3)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pce      (pce),
    .async_in ({supply_low, central_en_pin, module_en_pin}),
    .sync_out (pins_s)
  );

  assign supply_low_s = pins_s[2];
  assign src.central    = pins_s[1];
  assign src.module_en  = pins_s[0];
  assign src.ctrl_word  = ctrl[CTRL_PWR];
  assign src.fault_free = !internal_fault_source;
  assign power_req   = (&src) && !supply_low_s;
  assign has_shutoff = cfg[CFG_SHUTOFF] | cfg[CFG_AXIS_SOV];
  assign keep_servo  = cfg[CFG_KEEP_SRV];

  vpes_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_pe_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .pce      (pce),
    .run      (pe_run),
    .limit_ms (ped),
    .done     (pe_done)
  );

  vpes_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_oe_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .pce      (pce),
    .run      (oe_run),
    .limit_ms (oed),
    .done     (oe_done)
  );

  // sequencing of valve supplies and grants
  always_comb begin
    next_state  = state;
    next_valves = valves;
    case (state)
      ST_OFF: begin
        if (power_req) begin
          next_valves.servo = 1'b1;
          if (valves.servo) begin
            next_valves.shutoff = 1'b1;
            next_state          = ST_OE;
          end else begin
            next_state = ST_PE;
          end
        end
      end
      ST_PE, ST_OE, ST_RUN: begin
        if (!power_req) begin
          next_valves.shutoff = 1'b0;
          if (!has_shutoff) begin
            next_valves.servo = 1'b0;
            next_state        = ST_OFF;
          end else if (keep_servo) begin
            next_state = ST_OFF;
          end else begin
            next_state = ST_PD;
          end
        end else if (state == ST_PE && pe_done) begin
          next_valves.shutoff = 1'b1;
          next_state          = ST_OE;
        end else if (state == ST_OE && oe_done) begin
          next_state = ST_RUN;
        end
      end
      ST_PD: begin
        if (power_req) begin
          next_valves.shutoff = 1'b1;
          next_state          = ST_OE;
        end else if (oe_done) begin
          next_valves.servo = 1'b0;
          next_state        = ST_OFF;
        end
      end
      default: begin
        next_valves = '0;
        next_state  = ST_OFF;
      end
    endcase
    if (supply_low_s) begin
      next_valves = '0;
      next_state  = ST_OFF;
    end
    // timers restart on every state change
    next_pe_run = (next_state == ST_PE) && (next_state == state);
    next_oe_run = (next_state == ST_OE || next_state == ST_PD)
                  && (next_state == state);
    next_power_grant = (next_state == ST_OE) || (next_state == ST_RUN);
    next_vel_enable  = (next_state == ST_RUN) && ctrl[CTRL_VEL] && power_req
                       && next_valves.servo && next_valves.shutoff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= ST_OFF;
      valves         <= '0;
      power_grant    <= 1'b0;
      vel_enable     <= 1'b0;
      supply_missing <= 1'b0;
      pe_run         <= 1'b0;
      oe_run         <= 1'b0;
    end else if (pce) begin
      state          <= next_state;
      valves         <= next_valves;
      power_grant    <= next_power_grant;
      vel_enable     <= next_vel_enable;
      supply_missing <= supply_low_s;
      pe_run         <= next_pe_run;
      oe_run         <= next_oe_run;
    end
  end

  // apb registers, no wait states, interrupts
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready && pwrite;

  always_comb begin
    ev              = '0;
    ev[EV_LOST]     = supply_low_s && !supply_missing;
    ev[EV_BACK]     = !supply_low_s && supply_missing;
    ev[EV_VEL]      = next_vel_enable && !vel_enable;
    ev[EV_REVOKE]   = power_grant && !next_power_grant;
    next_ped   = ped;
    next_cfg   = cfg;
    next_oed   = oed;
    next_ctrl  = ctrl;
    next_imask = imask;
    next_istat = istat;
    if (wr) begin
      case (paddr)
        ADDR_PED:   next_ped   = vpes_clamp(pwdata[15:0], PED_MAX);
        ADDR_CFG:   next_cfg   = pwdata[15:0] & CFG_MASK;
        ADDR_OED:   next_oed   = vpes_clamp(pwdata[15:0], OED_MAX);
        ADDR_CTRL:  next_ctrl  = pwdata[1:0];
        ADDR_IMASK: next_imask = pwdata[NUM_EV-1:0];
        ADDR_ISTAT: next_istat = istat & ~pwdata[NUM_EV-1:0];
        default:    next_ctrl  = ctrl;
      endcase
    end
    next_istat   = next_istat | ev;
    next_irq     = |(next_istat & next_imask);
    next_pready  = setup;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (setup) begin
      case (paddr)
        ADDR_PED:   next_prdata[15:0]       = ped;
        ADDR_CFG:   next_prdata[15:0]       = cfg;
        ADDR_OED:   next_prdata[15:0]       = oed;
        ADDR_CTRL:  next_prdata[1:0]        = ctrl;
        ADDR_STAT:  next_prdata[7:0]        = {state, vel_enable,
                                               valves.shutoff, valves.servo,
                                               power_grant, supply_missing};
        ADDR_ISTAT: next_prdata[NUM_EV-1:0] = istat;
        ADDR_IMASK: next_prdata[NUM_EV-1:0] = imask;
        default:    next_pslverr            = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ped     <= PED_RESET;
      cfg     <= CFG_RESET;
      oed     <= OED_RESET;
      ctrl    <= '0;
      imask   <= '0;
      istat   <= '0;
      irq     <= 1'b0;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (pce) begin
      ped     <= next_ped;
      cfg     <= next_cfg;
      oed     <= next_oed;
      ctrl    <= next_ctrl;
      imask   <= next_imask;
      istat   <= next_istat;
      irq     <= next_irq;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_revoke;
    pce && power_grant && !power_req;
  endsequence

  property p_missing_flag;
    pce && supply_low_s |=> supply_missing;
  endproperty
  a_missing_flag: assert property (p_missing_flag)
    else $error("supply missing flag not set");

  property p_reject;
    supply_missing |-> !power_grant && !vel_enable;
  endproperty
  a_reject: assert property (p_reject)
    else $error("power granted while supply missing");

  property p_fail_off;
    supply_missing |-> valves == '0;
  endproperty
  a_fail_off: assert property (p_fail_off)
    else $error("valve supply on while supply missing");

  property p_pe_hold;
    state == ST_PE |-> !valves.shutoff && !power_grant && valves.servo;
  endproperty
  a_pe_hold: assert property (p_pe_hold)
    else $error("shut-off supply or grant during power delay");

  property p_vel_cond;
    vel_enable |-> valves.servo && valves.shutoff && power_grant
                   && state == ST_RUN;
  endproperty
  a_vel_cond: assert property (p_vel_cond)
    else $error("velocity enable without its conditions");

  property p_fault_drop;
    pce && internal_fault_source |=> !vel_enable && !power_grant;
  endproperty
  a_fault_drop: assert property (p_fault_drop)
    else $error("velocity enable kept during fault");

  property p_revoke;
    s_revoke |=> !valves.shutoff && !power_grant && !vel_enable;
  endproperty
  a_revoke: assert property (p_revoke)
    else $error("shut-off supply kept after disable");

  property p_servo_on;
    pce && state == ST_OFF && power_req |=> valves.servo;
  endproperty
  a_servo_on: assert property (p_servo_on)
    else $error("servo supply not switched on");

  property p_keep_servo;
    s_revoke ##0 (keep_servo && has_shutoff && !supply_low_s)
      |=> valves.servo && state == ST_OFF;
  endproperty
  a_keep_servo: assert property (p_keep_servo)
    else $error("servo supply dropped despite keep setting");

  property p_no_shutoff;
    s_revoke ##0 !has_shutoff |=> !valves.servo;
  endproperty
  a_no_shutoff: assert property (p_no_shutoff)
    else $error("servo supply kept without shut-off valve");

  property p_oe_wait;
    pce && state == ST_OE && !oe_done |=> !vel_enable;
  endproperty
  a_oe_wait: assert property (p_oe_wait)
    else $error("velocity enable before output delay");

  property p_limits;
    ped <= PED_MAX && oed <= OED_MAX;
  endproperty
  a_limits: assert property (p_limits)
    else $error("delay register above its limit");
endmodule : vpes_seq
`default_nettype wire

/* File: vpes_sync.sv */
/*
  Two-stage synchroniser for asynchronous pin levels.
  Assumes the caller reads only sync_out.
*/
`timescale 1ns/1ps
`default_nettype none
module vpes_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             pce,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (pce) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : vpes_sync
`default_nettype wire

/* File: vpes_valve_supply.sv */
/*
  Far-side model: external valve supply and the two enable pins.
  Assumes the bench sets wanted levels; pins change on pclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module vpes_valve_supply
  import vpes_pkg::*;
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // bench commands
  input  wire logic         supply_ok,
  input  wire logic         central_on,
  input  wire logic         module_on,
  // pins
  input  wire vpes_valves_t valves,
  output logic              supply_low,
  output logic              central_en_pin,
  output logic              module_en_pin,
  output logic              order_err
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_low     <= 1'b0;
      central_en_pin <= 1'b0;
      module_en_pin  <= 1'b0;
      order_err      <= 1'b0;
    end else begin
      supply_low     <= !supply_ok;
      central_en_pin <= central_on;
      module_en_pin  <= module_on;
      // shut-off supply must never lead the servo supply
      if (valves.shutoff && !valves.servo) begin
        order_err <= 1'b1;
      end
    end
  end
endmodule : vpes_valve_supply
`default_nettype wire
